// File: rtl/abx_pkg.sv
// constants and types for the alu and branch execute block
// What this block does
// - add registers, optional carry, full flags
// - subtract register or constant, full flags
// - subtract operand and carry, full flags
// - and/or/xor update zero, negative, overflow
// - set-bits ors mask, updates three flags
// - clear-bits ands with ff minus mask
// - test ands register with itself, flags
// - compare subtracts, no store, five flags
// - equal registers skip next, one/two clocks
// - register bit match skips next instruction
// - io bit match skips next instruction
// - any status bit branches to pc+k+1
// - zero flag branches equal / not equal
// - carry branches set or clear
// - same-or-higher on c=0, lower on c=1
// - signed branches test n xor v
// - half-carry branches set or clear
// - transfer flag branches set or clear
// - overflow branches set or clear
// - interrupt-enabled branch when i is one
package abx_pkg;
   // datapath widths
   localparam int DW     = 8;
   localparam int PCW    = 12;                  // program counter width, plain default
   localparam int KW     = 7;                   // signed branch offset width
   localparam int AW     = 6;                   // register port address width
   // register port map
   localparam logic [AW-1:0] STATUS_ADDR  = 6'h3F;
   localparam logic [DW-1:0] STATUS_RESET = 8'h00;
   localparam logic [DW-1:0] ALL_ONES     = 8'hFF;
   // status bit positions
   localparam int FC = 0;
   localparam int FZ = 1;
   localparam int FN = 2;
   localparam int FV = 3;
   localparam int FS = 4;
   localparam int FH = 5;
   localparam int FT = 6;
   localparam int FI = 7;
   // skip distances in words
   localparam logic [PCW-1:0] STEP_ONE   = 12'h001;
   localparam logic [PCW-1:0] STEP_SHORT = 12'h002;
   localparam logic [PCW-1:0] STEP_LONG  = 12'h003;
   // operations accepted on op_i
   typedef enum logic [5:0] {
      OP_ADD        = 6'h00, OP_ADD_CARRY  = 6'h01,
      OP_SUB        = 6'h02, OP_SUB_IMM    = 6'h03,
      OP_SUB_BORROW = 6'h04, OP_SUB_IMM_BW = 6'h05,
      OP_AND        = 6'h06, OP_AND_IMM    = 6'h07,
      OP_OR         = 6'h08, OP_OR_IMM     = 6'h09,
      OP_XOR        = 6'h0A, OP_SET_MASK   = 6'h0B,
      OP_CLR_MASK   = 6'h0C, OP_TEST       = 6'h0D,
      OP_CMP        = 6'h0E, OP_CMP_CARRY  = 6'h0F,
      OP_CMP_IMM    = 6'h10, OP_CMP_SKIP   = 6'h11,
      OP_SKIP_RB_CL = 6'h12, OP_SKIP_RB_ST = 6'h13,
      OP_SKIP_IO_CL = 6'h14, OP_SKIP_IO_ST = 6'h15,
      OP_BR_FLAG_ST = 6'h16, OP_BR_FLAG_CL = 6'h17,
      OP_BR_EQ      = 6'h18, OP_BR_NE      = 6'h19,
      OP_BR_C_SET   = 6'h1A, OP_BR_C_CLR   = 6'h1B,
      OP_BR_SAME_HI = 6'h1C, OP_BR_LOWER   = 6'h1D,
      OP_BR_SGE     = 6'h1E, OP_BR_SLT     = 6'h1F,
      OP_BR_H_SET   = 6'h20, OP_BR_H_CLR   = 6'h21,
      OP_BR_T_SET   = 6'h22, OP_BR_T_CLR   = 6'h23,
      OP_BR_V_SET   = 6'h24, OP_BR_V_CLR   = 6'h25,
      OP_BR_IRQ_EN  = 6'h26
   } abx_op_type;
   // sequencer states
   typedef enum logic [0:0] {
      ST_IDLE   = 1'b0,
      ST_SECOND = 1'b1
   } abx_state_type;
endpackage

// File: rtl/abx_exec.sv
// alu, compare, skip and branch execute unit with its status flags
`timescale 1ns/100ps
module abx_exec
   import abx_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             start_i,          // one-cycle instruction issue
   input  wire abx_op_type       op_i,             // operation to execute
   input  wire logic [DW-1:0]    dst_i,            // destination register value
   input  wire logic [DW-1:0]    src_i,            // source register value
   input  wire logic [DW-1:0]    imm_i,            // immediate constant or mask
   input  wire logic [2:0]       sel_i,            // bit or status flag select
   input  wire logic             io_bit_i,         // selected io register bit
   input  wire logic [KW-1:0]    offset_i,         // signed branch offset
   input  wire logic [PCW-1:0]   pc_i,             // address of this instruction
   input  wire logic             next_two_word_i,  // following instruction is two words
   input  wire logic [AW-1:0]    reg_addr_i,
   input  wire logic [DW-1:0]    reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output logic      [DW-1:0]    reg_rdata_o,
   output logic      [DW-1:0]    result_o,         // value to write back
   output logic                  result_we_o,      // write back pulse
   output logic      [PCW-1:0]   pc_o,             // next program counter
   output logic                  done_o,           // instruction finished pulse
   output logic                  busy_o,           // second clock of a taken redirect
   output logic      [DW-1:0]    flags_o           // status flags
);

   logic [DW-1:0]    status_r;        // status flags register
   abx_state_type    state_r;         // sequencer
   logic             accept;          // start taken this cycle
   // operand steering
   logic             use_imm;         // second operand is the constant
   logic             use_cin;         // carry flag enters the operation
   logic [DW-1:0]    opb;             // second operand
   logic             cin;             // carry or borrow in
   // arithmetic
   logic [DW:0]      sum9;            // 9-bit sum, msb is carry out
   logic [4:0]       sumh;            // low nibble sum, msb is half carry
   logic [DW:0]      dif9;            // 9-bit difference, msb is borrow
   logic [4:0]       difh;            // low nibble difference
   // result and flags
   logic [DW-1:0]    res;             // alu result
   logic             res_we;          // result is stored
   logic [DW-1:0]    flags_nxt;       // updated status flags
   // program flow
   logic             redirect;        // skip or branch taken
   logic             is_flow;         // op is a skip or branch
   logic [PCW-1:0]   pc_nxt;          // next program counter
   logic [PCW-1:0]   k_ext;           // sign extended offset
   logic             cond;            // selected condition bit
   logic             want;            // value of cond that redirects

   // a new instruction is only taken while idle; issue during busy is ignored
   assign accept = start_i && (state_r == ST_IDLE);

   // choose the second operand and whether carry takes part
   always_comb begin
      use_imm = 1'b0;
      use_cin = 1'b0;
      unique case (op_i)
         OP_ADD_CARRY, OP_SUB_BORROW, OP_CMP_CARRY: begin
            use_cin = 1'b1;
         end
         OP_SUB_IMM_BW: begin
            use_imm = 1'b1;
            use_cin = 1'b1;
         end
         OP_SUB_IMM, OP_AND_IMM, OP_OR_IMM, OP_SET_MASK, OP_CLR_MASK, OP_CMP_IMM: begin
            use_imm = 1'b1;
         end
         default: begin
            use_imm = 1'b0;   // register forms and flow ops
         end
      endcase
   end

   assign opb = use_imm ? imm_i : src_i;
   assign cin = use_cin & status_r[FC];

   // shared adder and subtractor; carry out and half carry come from the top bits
   assign sum9 = {1'b0, dst_i} + {1'b0, opb} + {8'h00, cin};
   assign sumh = {1'b0, dst_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   assign dif9 = {1'b0, dst_i} - {1'b0, opb} - {8'h00, cin};
   assign difh = {1'b0, dst_i[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};

   // result and flag update; flags not named by the op keep their value
   always_comb begin
      res       = dst_i;
      res_we    = 1'b0;
      flags_nxt = status_r;
      unique case (op_i)
         OP_ADD, OP_ADD_CARRY: begin
            res           = sum9[DW-1:0];
            res_we        = 1'b1;
            flags_nxt[FC] = sum9[DW];
            flags_nxt[FH] = sumh[4];
            flags_nxt[FV] = (dst_i[7] & opb[7] & ~res[7]) | (~dst_i[7] & ~opb[7] & res[7]);
            flags_nxt[FN] = res[7];
            flags_nxt[FZ] = (res == 8'h00);
         end
         OP_SUB, OP_SUB_IMM, OP_SUB_BORROW, OP_SUB_IMM_BW,
         OP_CMP, OP_CMP_CARRY, OP_CMP_IMM: begin
            res           = dif9[DW-1:0];
            // compares only set flags, the destination is left alone
            res_we        = (op_i != OP_CMP) && (op_i != OP_CMP_CARRY) && (op_i != OP_CMP_IMM);
            flags_nxt[FC] = dif9[DW];
            flags_nxt[FH] = difh[4];
            flags_nxt[FV] = (dst_i[7] & ~opb[7] & ~res[7]) | (~dst_i[7] & opb[7] & res[7]);
            flags_nxt[FN] = res[7];
            flags_nxt[FZ] = (res == 8'h00);
         end
         OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
         OP_SET_MASK, OP_CLR_MASK, OP_TEST: begin
            unique case (op_i)
               OP_AND, OP_AND_IMM: res = dst_i & opb;
               OP_OR, OP_OR_IMM:   res = dst_i | opb;
               OP_XOR:             res = dst_i ^ opb;
               OP_SET_MASK:        res = dst_i | opb;
               OP_CLR_MASK:        res = dst_i & (ALL_ONES - opb);
               default:            res = dst_i & dst_i;
            endcase
            // carry and half carry are not touched by logic ops
            res_we        = (op_i != OP_TEST);
            flags_nxt[FV] = 1'b0;
            flags_nxt[FN] = res[7];
            flags_nxt[FZ] = (res == 8'h00);
         end
         default: begin
            res    = dst_i;   // skips and branches change no flag
            res_we = 1'b0;
         end
      endcase
   end

   // pick the condition bit and the polarity that redirects
   always_comb begin
      cond    = 1'b0;
      want    = 1'b1;
      is_flow = 1'b1;
      unique case (op_i)
         OP_CMP_SKIP: cond = (dst_i == src_i);
         OP_SKIP_RB_CL: begin
            cond = dst_i[sel_i];
            want = 1'b0;
         end
         OP_SKIP_RB_ST: cond = dst_i[sel_i];
         OP_SKIP_IO_CL: begin
            cond = io_bit_i;
            want = 1'b0;
         end
         OP_SKIP_IO_ST: cond = io_bit_i;
         OP_BR_FLAG_ST: cond = status_r[sel_i];
         OP_BR_FLAG_CL: begin
            cond = status_r[sel_i];
            want = 1'b0;
         end
         OP_BR_EQ: cond = status_r[FZ];
         OP_BR_NE: begin
            cond = status_r[FZ];
            want = 1'b0;
         end
         OP_BR_C_SET: cond = status_r[FC];
         OP_BR_C_CLR: begin
            cond = status_r[FC];
            want = 1'b0;
         end
         OP_BR_LOWER: cond = status_r[FC];
         OP_BR_SAME_HI: begin
            cond = status_r[FC];
            want = 1'b0;
         end
         OP_BR_SLT: cond = status_r[FN] ^ status_r[FV];
         OP_BR_SGE: begin
            cond = status_r[FN] ^ status_r[FV];
            want = 1'b0;
         end
         OP_BR_H_SET: cond = status_r[FH];
         OP_BR_H_CLR: begin
            cond = status_r[FH];
            want = 1'b0;
         end
         OP_BR_T_SET: cond = status_r[FT];
         OP_BR_T_CLR: begin
            cond = status_r[FT];
            want = 1'b0;
         end
         OP_BR_V_SET: cond = status_r[FV];
         OP_BR_V_CLR: begin
            cond = status_r[FV];
            want = 1'b0;
         end
         OP_BR_IRQ_EN: cond = status_r[FI];
         default: begin
            is_flow = 1'b0;   // alu ops never redirect
         end
      endcase
   end

   assign redirect = is_flow && (cond == want);
   assign k_ext    = {{(PCW-KW){offset_i[KW-1]}}, offset_i};

   // next address: skips step over one or two words, branches add k+1
   always_comb begin
      pc_nxt = pc_i + STEP_ONE;
      if (redirect) begin
         if (op_i == OP_CMP_SKIP || op_i == OP_SKIP_RB_CL || op_i == OP_SKIP_RB_ST ||
             op_i == OP_SKIP_IO_CL || op_i == OP_SKIP_IO_ST) begin
            pc_nxt = next_two_word_i ? pc_i + STEP_LONG : pc_i + STEP_SHORT;
         end else begin
            pc_nxt = pc_i + k_ext + STEP_ONE;
         end
      end
   end

   // sequencer: a taken skip or branch holds one extra clock
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (accept && redirect) begin
                  state_r <= ST_SECOND;
               end
            end
            ST_SECOND: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // completion pulse: one clock after issue, or two when redirected
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         done_o <= (accept && !redirect) || (state_r == ST_SECOND);
         busy_o <= accept && redirect;
      end
   end

   // write back and program counter, captured at issue
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_o    <= 8'h00;
         result_we_o <= 1'b0;
         pc_o        <= 12'h000;
      end else begin
         result_we_o <= accept && res_we;
         if (accept) begin
            result_o <= res;
            pc_o     <= pc_nxt;
         end
      end
   end

   // status flags: execution update wins over a software write in the same cycle,
   // so a flag the alu just produced is never lost
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_r <= STATUS_RESET;
      end else if (accept) begin
         status_r <= flags_nxt;
      end else if (reg_wr_i && reg_addr_i == STATUS_ADDR) begin
         status_r <= reg_wdata_i;
      end
   end

   // flag output mirrors the register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_o <= STATUS_RESET;
      end else if (accept) begin
         flags_o <= flags_nxt;
      end else if (reg_wr_i && reg_addr_i == STATUS_ADDR) begin
         flags_o <= reg_wdata_i;
      end
   end

   // read port: data the cycle after the strobe, zero for unmapped addresses
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= (reg_addr_i == STATUS_ADDR) ? status_r : 8'h00;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule // abx_exec

// File: bench/abx_exec_asserts.sv
// port checker for the alu and branch execute unit
`timescale 1ns/100ps
module abx_exec_asserts
   import abx_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             start_i,
   input  wire abx_op_type       op_i,
   input  wire logic [DW-1:0]    dst_i,
   input  wire logic [DW-1:0]    src_i,
   input  wire logic [KW-1:0]    offset_i,
   input  wire logic [PCW-1:0]   pc_i,
   input  wire logic [DW-1:0]    result_o,
   input  wire logic             result_we_o,
   input  wire logic [PCW-1:0]   pc_o,
   input  wire logic             done_o,
   input  wire logic             busy_o,
   input  wire logic [DW-1:0]    flags_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // an issue only counts while the sequencer is idle
   wire logic           go_w   = start_i && !busy_o;
   wire logic [DW-1:0]  add_w  = dst_i + src_i;
   wire logic [DW-1:0]  sub_w  = dst_i - src_i;
   wire logic [PCW-1:0] seq_w  = pc_i + STEP_ONE;
   // offset is sign extended, so backward targets wrap correctly
   wire logic [PCW-1:0] tgt_w  = pc_i + {{(PCW-KW){offset_i[KW-1]}}, offset_i} + STEP_ONE;
   wire logic           sge_w  = flags_o[FN] == flags_o[FV];
   wire logic           flow_w = op_i >= OP_CMP_SKIP;   // skips and branches
   a_add_sum: assert property (go_w && op_i == OP_ADD |=> result_o == $past(add_w) && result_we_o && done_o)
      else $error("add result or write back wrong");
   a_sub_diff: assert property (go_w && op_i == OP_SUB |=> result_o == $past(sub_w) && result_we_o)
      else $error("subtract result wrong");
   a_alu_next_pc: assert property (go_w && !flow_w |=> pc_o == $past(seq_w) && !busy_o && done_o)
      else $error("alu op did not finish in one clock");
   a_logic_keeps_carry: assert property (go_w && op_i inside {[OP_AND:OP_TEST]} |=> $stable(flags_o[FC]) && !flags_o[FV])
      else $error("logic op touched carry or left overflow set");
   a_cmp_no_store: assert property (go_w && op_i inside {OP_CMP, OP_CMP_CARRY, OP_CMP_IMM, OP_TEST} |=> !result_we_o)
      else $error("compare wrote back a result");
   a_flow_flags: assert property (go_w && flow_w |=> $stable(flags_o))
      else $error("skip or branch changed status flags");
   a_beq_taken: assert property (go_w && op_i == OP_BR_EQ && flags_o[FZ]
      |=> busy_o && !done_o && pc_o == $past(tgt_w) ##1 done_o && !busy_o)
      else $error("taken equal branch wrong target or timing");
   a_bne_not_taken: assert property (go_w && op_i == OP_BR_NE && flags_o[FZ] |=> done_o && !busy_o && pc_o == $past(seq_w))
      else $error("not-equal branch taken while zero set");
   a_sge_decision: assert property (go_w && op_i == OP_BR_SGE |=> busy_o == $past(sge_w))
      else $error("signed branch decision wrong");
   a_busy_once: assert property (busy_o |=> !busy_o && done_o)
      else $error("redirect did not finish in two clocks");
   a_skip_equal: assert property (go_w && op_i == OP_CMP_SKIP && dst_i == src_i |=> busy_o ##1 done_o)
      else $error("equal compare did not skip");
   c_add: cover property (go_w && op_i == OP_ADD);
   c_taken: cover property (go_w && flow_w ##1 busy_o);
   c_refused: cover property (busy_o && start_i);
endmodule // abx_exec_asserts

// File: bench/alu_and_branch_execute_bench.sv
// self-checking bench for the alu and branch execute unit
`timescale 1ns/100ps
module alu_and_branch_execute_bench;
   import abx_pkg::*;
   logic             clk_i = 1'b0;
   logic             resetn_i = 1'b0;
   logic             start_i = 1'b0;
   abx_op_type       op_i = OP_ADD;
   logic [DW-1:0]    dst_i = 8'h00, src_i = 8'h00, imm_i = 8'h00;
   logic [2:0]       sel_i = 3'h0;
   logic             io_bit_i = 1'b1, next_two_word_i = 1'b0;
   logic [KW-1:0]    offset_i = 7'h00;
   logic [PCW-1:0]   pc_i = 12'h010;
   logic [AW-1:0]    reg_addr_i = 6'h00;
   logic [DW-1:0]    reg_wdata_i = 8'h00, reg_rdata_o, result_o, flags_o, rd;
   logic             reg_wr_i = 1'b0, reg_rd_i = 1'b0, result_we_o, done_o, busy_o;
   logic [PCW-1:0]   pc_o;
   logic [31:0]      got;              // we, done, busy, late done, result, flags, pc
   logic             ign_res = 1'b0;   // result is not checked for compares, test and flow ops
   int               fail_count = 0, n_compared = 0, cycles = 0;
   abx_exec dut (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i), .dst_i(dst_i),
      .src_i(src_i), .imm_i(imm_i), .sel_i(sel_i), .io_bit_i(io_bit_i), .offset_i(offset_i), .pc_i(pc_i),
      .next_two_word_i(next_two_word_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .result_o(result_o),
      .result_we_o(result_we_o), .pc_o(pc_o), .done_o(done_o), .busy_o(busy_o), .flags_o(flags_o));
   // 200 mhz clock
   always #2.5 clk_i = ~clk_i;
   // a hang is cut short far beyond the roughly 170 cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         fail_count++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one-cycle register write strobe
   task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // issue one instruction and gather its whole outcome, waiting out a redirect
   task automatic run(input abx_op_type op, input logic [DW-1:0] d, s, m, output logic [31:0] o);
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= op;
      dst_i <= d;
      src_i <= s;
      imm_i <= m;
      @(posedge clk_i);
      start_i <= 1'b0;
      #1 o = {result_we_o, done_o, busy_o, 1'b0, ign_res ? 8'h00 : result_o, flags_o, pc_o};
      if (busy_o === 1'b1) begin
         @(posedge clk_i);
         #1 o[28] = done_o;
      end
   endtask
   // status port: reset value, unmapped place, write back, issue refused while busy
   task automatic t_regs();
      reg_rd(STATUS_ADDR, rd);
      check(rd, 8'h00);
      reg_rd(6'h00, rd);
      check(rd, 8'h00);
      reg_wr(STATUS_ADDR, 8'hA5);
      reg_rd(STATUS_ADDR, rd);
      check(rd, 8'hA5);
      reg_wr(STATUS_ADDR, 8'h02);
      pc_i <= 12'h100;
      offset_i <= 7'h7E;
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= OP_BR_EQ;
      @(posedge clk_i);
      op_i <= OP_ADD;   // start held into the busy cycle must be ignored
      @(posedge clk_i);
      start_i <= 1'b0;
      #1 check({done_o, result_we_o, pc_o, flags_o}, {2'b10, 12'h0FF, 8'h02});
   endtask
   task automatic t_arith();
      pc_i <= 12'h010;
      reg_wr(STATUS_ADDR, 8'hC1);
      run(OP_ADD, 8'h0F, 8'h01, 8'h00, got);
      check(got, {4'b1100, 8'h10, 8'hE0, 12'h011});
      reg_wr(STATUS_ADDR, 8'h01);
      run(OP_ADD_CARRY, 8'h7F, 8'h00, 8'h00, got);
      check(got, {4'b1100, 8'h80, 8'h2C, 12'h011});
      run(OP_SUB, 8'h00, 8'h01, 8'h00, got);
      check(got, {4'b1100, 8'hFF, 8'h25, 12'h011});
      run(OP_SUB_IMM, 8'h80, 8'hAA, 8'h01, got);
      check(got, {4'b1100, 8'h7F, 8'h28, 12'h011});
      reg_wr(STATUS_ADDR, 8'h01);
      run(OP_SUB_BORROW, 8'h10, 8'h0F, 8'h00, got);
      check(got, {4'b1100, 8'h00, 8'h22, 12'h011});
      reg_wr(STATUS_ADDR, 8'h01);
      run(OP_SUB_IMM_BW, 8'h05, 8'h00, 8'h04, got);
      check(got, {4'b1100, 8'h00, 8'h02, 12'h011});
      ign_res = 1'b1;
      run(OP_CMP, 8'h10, 8'h20, 8'h00, got);
      check(got, {4'b0100, 8'h00, 8'h05, 12'h011});
      run(OP_CMP_IMM, 8'h20, 8'h55, 8'h20, got);
      check(got, {4'b0100, 8'h00, 8'h02, 12'h011});
      reg_wr(STATUS_ADDR, 8'h01);
      run(OP_CMP_CARRY, 8'h20, 8'h1F, 8'h00, got);
      check(got, {4'b0100, 8'h00, 8'h22, 12'h011});
   endtask
   // logic ops: carry and half-carry kept, overflow cleared, zero and negative from result
   task automatic t_logic();
      abx_op_type ops[8] = '{OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_SET_MASK, OP_CLR_MASK, OP_TEST};
      logic [7:0] res[8] = '{8'h30, 8'h00, 8'hFC, 8'hFF, 8'hCC, 8'hFF, 8'hF0, 8'h00};
      logic [7:0] flg[8] = '{8'h21, 8'h23, 8'h25, 8'h25, 8'h25, 8'h25, 8'h25, 8'h25};
      for (int i = 0; i < 8; i++) begin
         ign_res = (i == 7);
         reg_wr(STATUS_ADDR, 8'h29);
         run(ops[i], 8'hF0, 8'h3C, 8'h0F, got);
         check(got, {i != 7, 3'b100, res[i], flg[i], 12'h011});
      end
   endtask
   // skips: distance two or three words by the following instruction's length
   task automatic t_skip();
      abx_op_type ops[6] = '{OP_CMP_SKIP, OP_CMP_SKIP, OP_SKIP_RB_CL, OP_SKIP_RB_ST, OP_SKIP_IO_CL, OP_SKIP_IO_ST};
      logic [7:0] dv[6] = '{8'h5A, 8'h5A, 8'hFB, 8'hFB, 8'h00, 8'h00};
      logic [5:0] two_v = 6'b000110;
      logic [5:0] take_v = 6'b100101;
      ign_res = 1'b1;
      sel_i <= 3'h2;
      reg_wr(STATUS_ADDR, 8'h55);
      for (int i = 0; i < 6; i++) begin
         next_two_word_i <= two_v[i];
         run(ops[i], dv[i], dv[i] ^ {7'h00, i == 1}, 8'h00, got);
         if (take_v[i]) check(got, {4'b0011, 8'h00, 8'h55, 12'h012 + two_v[i]});
         else check(got, {4'b0100, 8'h00, 8'h55, 12'h011});
      end
   endtask
   // every flag branch once, interrupt enable both taken and not, backward and forward offsets
   task automatic t_branch();
      logic [7:0]  fl[18] = '{8'h10, 8'h40, 8'h02, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01, 8'h0C,
                              8'h04, 8'h00, 8'h20, 8'h40, 8'h00, 8'h08, 8'h08, 8'h80, 8'h7F};
      logic [17:0] take_v = 18'b010111001110100101;
      logic [5:0]  code;
      logic [11:0] tgt;
      ign_res = 1'b1;
      pc_i <= 12'h100;
      for (int i = 0; i < 18; i++) begin
         code = (i == 17) ? 6'h26 : 6'h16 + 6'(i);
         tgt = i[0] ? 12'h140 : 12'h0FF;
         sel_i <= (i == 0) ? 3'h4 : 3'h6;
         offset_i <= i[0] ? 7'h3F : 7'h7E;
         reg_wr(STATUS_ADDR, fl[i]);
         run(abx_op_type'(code), 8'h00, 8'h00, 8'h00, got);
         if (take_v[i]) check(got, {4'b0011, 8'h00, fl[i], tgt});
         else check(got, {4'b0100, 8'h00, fl[i], 12'h101});
      end
   endtask
   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_arith();
      t_logic();
      t_skip();
      t_branch();
      stop_test();
   end
endmodule // alu_and_branch_execute_bench
bind abx_exec abx_exec_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i),
   .dst_i(dst_i), .src_i(src_i), .offset_i(offset_i), .pc_i(pc_i), .result_o(result_o),
   .result_we_o(result_we_o), .pc_o(pc_o), .done_o(done_o), .busy_o(busy_o), .flags_o(flags_o));
